// File: bench/upm_host_model.sv
// Host processor model driving the parallel register bus
`timescale 1ns/1ps
module upm_host_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_data_oe_n,
  input  wire logic [7:0] i_rd_data,
  output logic            o_cs_n,
  output logic            o_rd_n,
  output logic            o_wr_n,
  output logic      [2:0] o_addr,
  output logic      [7:0] o_data
);
  // Park the bus idle at time zero
  initial begin
    o_cs_n = 1'b1;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_addr = 3'h0;
    o_data = 8'h00;
  end
  // Released lines float to the inverse value; the gap lets the pin
  // filter see the release before the next access starts
  task automatic idle;
    o_cs_n = 1'b1;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_addr = ~o_addr;
    o_data = ~o_data;
    repeat (8) @(negedge i_clk_sys);
  endtask : idle
  // Strobe held four cycles so the filtered strobe stays low long enough
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge i_clk_sys);
    o_cs_n = 1'b0;
    o_wr_n = 1'b0;
    o_addr = a;
    o_data = d;
    repeat (4) @(negedge i_clk_sys);
    idle();
  endtask : wr
  // Read held until the device drives the bus; data taken at that edge,
  // since a read side effect may change the byte one cycle later
  task automatic rd(input logic [2:0] a, output logic [7:0] d,
                    output bit ok);
    int n;
    @(negedge i_clk_sys);
    o_cs_n = 1'b0;
    o_rd_n = 1'b0;
    o_addr = a;
    o_data = ~o_data;
    n = 0;
    while (i_data_oe_n !== 1'b0 && n < 12) begin
      @(negedge i_clk_sys);
      n++;
    end
    ok = (n < 12);
    d = i_rd_data;
    idle();
  endtask : rd
endmodule : upm_host_model

// File: bench/upm_top_tb_top.sv
// Self-checking bench for the UART power-mode and register-map block
`timescale 1ns/1ps
module upm_top_tb_top;
  localparam logic [7:0] REV = 8'h01; // Arbitrary value
  localparam logic [7:0] DEV = 8'h5a; // Arbitrary value
  logic i_clk_sys = 1'b0, i_rst = 1'b1, i_cs_n, i_read_strobe_n;
  logic i_write_strobe_n, i_auto_pump_shutdown_pin = 1'b0;
  logic i_power_save_pin = 1'b0, i_rx = 1'b1, i_osc_stable = 1'b0;
  logic i_tx_idle = 1'b1, i_tsr_out = 1'b0, i_int_pending = 1'b0;
  logic [2:0] i_addr;
  logic [3:0] i_modem_n = 4'hf, osc_cnt = 4'h0, n_rh = 4'h0;
  logic [3:0] n_tx = 4'h0, n_fw = 4'h0, n_tg = 4'h0, n_em = 4'h0;
  logic [7:0] i_data, i_int_src = 8'hc0, i_rx_hold = 8'h3c, rdv;
  logic [7:0] i_line_stat = 8'h60, i_fifo_cnt = 8'h21, i_fifo_lvl = 8'h42;
  logic [7:0] o_data, o_wr_data, o_div_frac, o_modem_ctl;
  logic [15:0] o_divisor;
  logic o_data_oe_n, o_rsr_in, o_osc_en, o_pump_en, o_pump_ready;
  logic o_drv_oe_n, o_asleep, o_power_save, o_wake_int, o_rx_hold_rd;
  logic o_tx_hold_wr, o_fifo_ctl_wr, o_trig_wr, o_emode_wr;
  int num_errors = 0, comparisons = 0, n;

  // Short idle and wake counts keep the run brief
  upm_top #(.IDLE_CYC(36'd200), .WAKE_CYC(16'd20), .EXT_OSC(1'b0),
    .REV_CODE(REV), .DEV_CODE(DEV)) u_upm_top (
    .i_clk_sys, .i_rst, .i_cs_n, .i_read_strobe_n, .i_write_strobe_n,
    .i_addr, .i_data, .o_data, .o_data_oe_n, .i_auto_pump_shutdown_pin,
    .i_power_save_pin, .i_rx, .i_modem_n, .i_osc_stable, .i_tx_idle,
    .i_tsr_out, .i_int_pending, .i_int_src, .i_rx_hold, .i_line_stat,
    .i_fifo_cnt, .i_fifo_lvl, .o_rsr_in, .o_osc_en, .o_pump_en,
    .o_pump_ready, .o_drv_oe_n, .o_asleep, .o_power_save, .o_wake_int,
    .o_rx_hold_rd, .o_tx_hold_wr, .o_fifo_ctl_wr, .o_trig_wr,
    .o_emode_wr, .o_wr_data, .o_divisor, .o_div_frac, .o_modem_ctl);
  upm_host_model u_upm_host_model (.i_clk_sys,
    .i_data_oe_n(o_data_oe_n), .i_rd_data(o_data), .o_cs_n(i_cs_n),
    .o_rd_n(i_read_strobe_n), .o_wr_n(i_write_strobe_n),
    .o_addr(i_addr), .o_data(i_data));

  // 250 MHz system clock
  always #2 i_clk_sys = ~i_clk_sys;
  // Count one-cycle pulses mid-cycle, where they have settled
  always @(negedge i_clk_sys) begin
    if (o_tx_hold_wr === 1'b1) n_tx <= n_tx + 4'h1;
    if (o_fifo_ctl_wr === 1'b1) n_fw <= n_fw + 4'h1;
    if (o_trig_wr === 1'b1) n_tg <= n_tg + 4'h1;
    if (o_emode_wr === 1'b1) n_em <= n_em + 4'h1;
    if (o_rx_hold_rd === 1'b1) n_rh <= n_rh + 4'h1;
  end
  // Crystal settles ten cycles after enable and stops at once when off
  always @(negedge i_clk_sys) begin
    osc_cnt <= (o_osc_en !== 1'b1) ? 4'h0 : osc_cnt + {3'h0, osc_cnt != 4'hf};
    i_osc_stable <= (osc_cnt > 4'h9);
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run
  function automatic logic pick(input int k);
    case (k)
      0: return o_pump_en;
      1: return o_pump_ready;
      2: return o_asleep;
      3: return o_power_save;
      default: return o_wake_int;
    endcase
  endfunction : pick
  // Bounded wait for a level; cycles taken are left in n
  task automatic wl(input int k, input logic v, input int lim);
    n = 0;
    while (pick(k) !== v) begin
      if (n >= lim) begin
        num_errors++;
        $display("wait %0d ran out at %0t", k, $time);
        complete_run();
      end
      @(negedge i_clk_sys);
      n++;
    end
  endtask : wl
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    u_upm_host_model.wr(a, d);
  endtask : wr
  task automatic rd(input logic [2:0] a);
    bit ok;
    u_upm_host_model.rd(a, rdv, ok);
    chk(ok, 1'b1);
    if (!ok) complete_run();
  endtask : rd
  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    rd(a);
    chk(rdv, e);
  endtask : rc

  // Reset, register map, loopback, pump, sleep and power-save in turn
  initial begin
    repeat (16) @(negedge i_clk_sys);
    i_rst = 1'b0;
    chk({o_pump_en, o_pump_ready, o_drv_oe_n, o_power_save}, 4'hc);
    $display("test reset done");
    wr(3'h3, 8'h80);
    rc(3'h0, REV);
    rc(3'h1, DEV);
    wr(3'h0, 8'h12);
    wr(3'h1, 8'h34);
    chk(o_divisor, 16'h3412);
    rc(3'h1, 8'h34);
    wr(3'h3, 8'h03);
    rc(3'h0, i_rx_hold);
    chk(n_rh, 4'h1);
    wr(3'h0, 8'h5e);
    chk({n_tx, o_wr_data}, 12'h15e);
    rc(3'h2, i_int_src);
    wr(3'h2, 8'h07);
    chk(n_fw, 4'h1);
    rc(3'h5, i_line_stat);
    wr(3'h7, 8'ha5);
    rc(3'h7, 8'ha5);
    wr(3'h3, 8'hbf);
    wr(3'h4, 8'h11);
    rc(3'h4, 8'h11);
    rc(3'h0, i_fifo_cnt);
    wr(3'h0, 8'h08);
    chk({n_tg, n_tx}, 8'h11);
    wr(3'h2, 8'h10);
    wr(3'h1, 8'h40);
    rc(3'h1, 8'h40);
    wr(3'h3, 8'h80);
    wr(3'h2, 8'h3b);
    rc(3'h2, 8'h0b);
    chk(o_div_frac, 8'h0b);
    wr(3'h3, 8'h03);
    rc(3'h7, i_fifo_lvl);
    wr(3'h7, 8'h9c);
    chk({n_em, o_wr_data}, 12'h19c);
    wr(3'h3, 8'hbf);
    wr(3'h1, 8'h00);
    wr(3'h3, 8'h03);
    $display("test register map done");
    wr(3'h4, 8'h10);
    chk(o_modem_ctl, 8'h10);
    i_tsr_out = 1'b1;
    @(negedge i_clk_sys);
    chk(o_rsr_in, 1'b1);
    i_tsr_out = 1'b0;
    @(negedge i_clk_sys);
    chk(o_rsr_in, 1'b0);
    wr(3'h4, 8'h00);
    chk(o_rsr_in, 1'b1);
    rd(3'h6);
    $display("test loopback done");
    i_auto_pump_shutdown_pin = 1'b1;
    wl(0, 1'b0, 300);
    chk(n >= 190 && n <= 215, 1'b1);
    chk(o_drv_oe_n, 1'b1);
    rc(3'h7, 8'ha5);
    i_rx = 1'b0;
    repeat (8) @(negedge i_clk_sys);
    i_rx = 1'b1;
    wl(0, 1'b1, 12);
    chk(o_pump_ready, 1'b0);
    wl(1, 1'b1, 40);
    chk(n >= 17 && n <= 23, 1'b1);
    $display("test pump idle done");
    wr(3'h1, 8'h10);
    wl(2, 1'b1, 40);
    chk(o_osc_en, 1'b0);
    wl(0, 1'b0, 3);
    wr(3'h0, 8'h55);
    chk({o_asleep, o_pump_en}, 2'h1);
    wl(4, 1'b1, 60);
    rd(3'h2);
    chk({rdv[3:0], o_wake_int}, 5'h02);
    wl(2, 1'b1, 40);
    $display("test sleep done");
    i_power_save_pin = 1'b1;
    wl(3, 1'b1, 20);
    wr(3'h7, 8'h77);
    i_modem_n[0] = 1'b0;
    wl(3, 1'b0, 20);
    chk(o_asleep, 1'b0);
    rc(3'h7, 8'ha5);
    rd(3'h6);
    wl(4, 1'b1, 60);
    rd(3'h2);
    wl(3, 1'b1, 60);
    i_power_save_pin = 1'b0;
    wl(3, 1'b0, 20);
    chk(o_asleep, 1'b1);
    $display("test power save done");
    i_auto_pump_shutdown_pin = 1'b0;
    wl(1, 1'b1, 40);
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h66);
    chk(n_tx, 4'h3);
    $display("test pump restore done");
    complete_run();
  end
endmodule : upm_top_tb_top

// File: core/upm_cfg.svh
// Constants for the UART power-mode and register-map block
`ifndef UPM_CFG_SVH
`define UPM_CFG_SVH

// Register addresses on the three address lines
`define UPM_OFF_HOLD       3'h0
`define UPM_OFF_INT_EN     3'h1
`define UPM_OFF_INT_SRC    3'h2
`define UPM_OFF_LINE_CTL   3'h3
`define UPM_OFF_MODEM_CTL  3'h4
`define UPM_OFF_LINE_STAT  3'h5
`define UPM_OFF_MODEM_STAT 3'h6
`define UPM_OFF_SCRATCH    3'h7

// Field positions and key values
`define UPM_LC_DIV_BIT     7
`define UPM_IE_SLEEP_BIT   4
`define UPM_MC_LOOP_BIT    4
`define UPM_EF_ENH_BIT     4
`define UPM_FT_SCR_BIT     6
`define UPM_LINE_ENH_KEY   8'hbf
`define UPM_RST_BYTE       8'h00
`define UPM_DIV_ZERO       16'h0000
`define UPM_SRC_WAKE       4'h1
`define UPM_FRAC_MASK      8'h0f

// Timing: figures as printed, clock rate
`define UPM_IDLE_S         30
`define UPM_WAKE_NS        45000
`define UPM_CLK_HZ         250000000
`define UPM_CLK_MHZ        250

`endif

// File: core/upm_pkg.sv
// Types for the UART power-mode and register-map block
package upm_pkg;

  // UART power state
  typedef enum logic [1:0] {
    UPM_ACTIVE, UPM_SLEEP
  } upm_pwr_t;

  // Charge pump state
  typedef enum logic [1:0] {
    UPM_PUMP_ON, UPM_PUMP_OFF, UPM_PUMP_WAKE
  } upm_pump_t;

  // Register selected by address and mode bits
  typedef enum logic [4:0] {
    R_HOLD, R_DIV_LO, R_DIV_HI, R_DIV_FRAC, R_REV, R_DEVID,
    R_INT_EN, R_INT_SRC, R_LINE_CTL, R_MODEM_CTL, R_LINE_STAT,
    R_MODEM_STAT, R_SCRATCH, R_FIFO_LVL, R_TRIG, R_FEAT,
    R_ENH_FN, R_RES1, R_RES2, R_PAUSE1, R_PAUSE2
  } upm_reg_t;

endpackage : upm_pkg

// File: core/upm_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module upm_sync3 #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] agree;

  // Only the second stage reads the first one
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
    end else begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign agree = ~(s2_q ^ s3_q);

  // A bit moves only once stages two and three agree
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_q <= RST;
    end else begin
      o_q <= (o_q & ~agree) | (s2_q & agree);
    end
  end

endmodule : upm_sync3

// File: core/upm_top.sv
// UART low-power control, loopback path and register decode
// What this block does
// RULE1 - Idle thirty seconds shuts pump when awake
// RULE2 - Pump off: drivers tri-stated, registers reachable
// RULE3 - Pump recovers about 45 us after wake
// RULE4 - Rx edge, transmit write, modem rise wake pump
// RULE5 - Host waits 45 us before sending
// RULE6 - Asleep with pin high: pump off immediately
// RULE7 - Power-save when pin high and asleep; isolate
// RULE8 - Power-save wakes on rx or modem change
// RULE9 - Re-enter power-save after status read, serviced
// RULE10 - Stay power-save until enable clear or pin low
// RULE11 - Wake interrupt once oscillator runs, read clears
// RULE12 - Loopback routes transmit shift into receiver
// RULE13 - Three address lines plus line-control pick register
// RULE14 - Address zero: receive read, transmit write
// RULE15 - Divisor bytes at 0,1; fraction at 2 enhanced
// RULE16 - Zero divisor reads give revision and identity
// RULE17 - Key value maps the enhanced register set
// RULE18 - Address seven: scratch or level and mode select
// RULE19 - Address two: status read, fifo control write
// RULE20 - Crystal wake may lose data; external does not
// RULE21 - Sleep needs idle, enabled, non-zero divisor
`timescale 1ns/1ps
`include "upm_cfg.svh"
module upm_top import upm_pkg::*; #(
  parameter logic [35:0] IDLE_CYC = 36'(64'(`UPM_IDLE_S) * 64'(`UPM_CLK_HZ)),
  parameter logic [15:0] WAKE_CYC =
    16'((`UPM_WAKE_NS * `UPM_CLK_MHZ + 999) / 1000),
  parameter bit          EXT_OSC  = 1'b0,
  parameter logic [7:0]  REV_CODE = 8'h01, // Arbitrary value
  parameter logic [7:0]  DEV_CODE = 8'h5a  // Arbitrary value
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  input  wire logic       i_cs_n,
  input  wire logic       i_read_strobe_n,
  input  wire logic       i_write_strobe_n,
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_data,
  output logic      [7:0] o_data,
  output logic            o_data_oe_n,
  input  wire logic       i_auto_pump_shutdown_pin,
  input  wire logic       i_power_save_pin,
  input  wire logic       i_rx,
  input  wire logic [3:0] i_modem_n,
  input  wire logic       i_osc_stable,
  input  wire logic       i_tx_idle,
  input  wire logic       i_tsr_out,
  input  wire logic       i_int_pending,
  input  wire logic [7:0] i_int_src,
  input  wire logic [7:0] i_rx_hold,
  input  wire logic [7:0] i_line_stat,
  input  wire logic [7:0] i_fifo_cnt,
  input  wire logic [7:0] i_fifo_lvl,
  output logic            o_rsr_in,
  output logic            o_osc_en,
  output logic            o_pump_en,
  output logic            o_pump_ready,
  output logic            o_drv_oe_n,
  output logic            o_asleep,
  output logic            o_power_save,
  output logic            o_wake_int,
  output logic            o_rx_hold_rd,
  output logic            o_tx_hold_wr,
  output logic            o_fifo_ctl_wr,
  output logic            o_trig_wr,
  output logic            o_emode_wr,
  output logic      [7:0] o_wr_data,
  output logic     [15:0] o_divisor,
  output logic      [7:0] o_div_frac,
  output logic      [7:0] o_modem_ctl
);

  logic [13:0] bus_f;
  logic [7:0]  pin_f;
  logic        cs_f, rd_f, wr_f, rx_f, acp_f, psp_f, osc_f;
  logic [3:0]  mdm_f;
  logic [2:0]  addr_f;
  logic [7:0]  data_f;
  logic        rd_act, wr_act, rd_prev_q, wr_prev_q, rd_start, wr_done;
  logic [2:0]  waddr_q;
  logic [7:0]  wdata_q;
  logic [7:0]  lctl_q, ien_q, dvlo_q, dvhi_q, dvfr_q, efn_q, feat_q, scr_q;
  logic [7:0]  mctl_q, res1_q, res2_q, pau1_q, pau2_q;
  logic [3:0]  mst_in, mst_prev_q, mst_dlt_q, mdm_prev_q;
  logic        rx_prev_q, loop, div_zero, tx_wr, mdm_rise;
  upm_reg_t    rsel, wsel;
  upm_pwr_t    pwr_q;
  upm_pump_t   pump_q;
  logic        ps_q, wake_wait_q, wake_int_q, sleep_ok, uart_wake;
  logic        pump_wake, idle_done;
  logic [35:0] idle_q;
  logic [15:0] wcnt_q;
  logic [7:0]  rd_mux;

  // Register select from address, line control and feature bits
  function automatic upm_reg_t upm_decode(input logic [2:0] a,
      input logic [7:0] lc, input logic efen, input logic ftsc,
      input logic dz, input logic rd);
    upm_reg_t r;
    r = R_LINE_CTL;
    if (lc == `UPM_LINE_ENH_KEY) begin // RULE17
      unique case (a)
        `UPM_OFF_HOLD:       r = R_TRIG;
        `UPM_OFF_INT_EN:     r = R_FEAT;
        `UPM_OFF_INT_SRC:    r = R_ENH_FN;
        `UPM_OFF_LINE_CTL:   r = R_LINE_CTL;
        `UPM_OFF_MODEM_CTL:  r = R_RES1;
        `UPM_OFF_LINE_STAT:  r = R_RES2;
        `UPM_OFF_MODEM_STAT: r = R_PAUSE1;
        `UPM_OFF_SCRATCH:    r = R_PAUSE2;
      endcase
    end else begin
      unique case (a)
        `UPM_OFF_HOLD: r = !lc[`UPM_LC_DIV_BIT] ? R_HOLD : // RULE14
          (dz && rd) ? R_REV : R_DIV_LO; // RULE15 RULE16
        `UPM_OFF_INT_EN: r = !lc[`UPM_LC_DIV_BIT] ? R_INT_EN :
          (dz && rd) ? R_DEVID : R_DIV_HI; // RULE15 RULE16
        `UPM_OFF_INT_SRC: r = (lc[`UPM_LC_DIV_BIT] && efen) ?
          R_DIV_FRAC : R_INT_SRC; // RULE15 RULE19
        `UPM_OFF_LINE_CTL:   r = R_LINE_CTL;
        `UPM_OFF_MODEM_CTL:  r = R_MODEM_CTL;
        `UPM_OFF_LINE_STAT:  r = R_LINE_STAT;
        `UPM_OFF_MODEM_STAT: r = R_MODEM_STAT;
        `UPM_OFF_SCRATCH:    r = ftsc ? R_FIFO_LVL : R_SCRATCH; // RULE18
      endcase
    end
    return r;
  endfunction : upm_decode

  // Bus pins and slow pins all pass the three-stage filter
  upm_sync3 #(.W(14), .RST(14'h3800)) u_bus_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_pin     ({i_cs_n, i_read_strobe_n, i_write_strobe_n, i_addr,
                 i_data}),
    .o_q       (bus_f)
  );
  // Modem pins reset to their idle high level so no false delta follows
  upm_sync3 #(.W(8), .RST(8'hf1)) u_pin_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_pin     ({i_modem_n, i_osc_stable, i_power_save_pin,
                 i_auto_pump_shutdown_pin, i_rx}),
    .o_q       (pin_f)
  );
  assign {cs_f, rd_f, wr_f, addr_f, data_f} = bus_f;
  assign {mdm_f, osc_f, psp_f, acp_f, rx_f} = pin_f;

  // Power-save gates the whole host interface off the core
  assign rd_act   = !cs_f && !rd_f && !ps_q; // RULE7 RULE13
  assign wr_act   = !cs_f && !wr_f && !ps_q; // RULE7 RULE13
  assign rd_start = rd_act && !rd_prev_q;
  assign wr_done  = wr_prev_q && !wr_act;

  // Write address and data are sampled every cycle while the strobe is low, the last sample used on release
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rd_prev_q <= 1'b0;
      wr_prev_q <= 1'b0;
      waddr_q   <= 3'h0;
      wdata_q   <= `UPM_RST_BYTE;
    end else begin
      rd_prev_q <= rd_act;
      wr_prev_q <= wr_act;
      if (wr_act) begin
        waddr_q <= addr_f;
        wdata_q <= data_f;
      end
    end
  end

  assign div_zero = {dvhi_q, dvlo_q} == `UPM_DIV_ZERO;
  assign rsel = upm_decode(addr_f, lctl_q, efn_q[`UPM_EF_ENH_BIT],
                           feat_q[`UPM_FT_SCR_BIT], div_zero, 1'b1);
  assign wsel = upm_decode(waddr_q, lctl_q, efn_q[`UPM_EF_ENH_BIT],
                           feat_q[`UPM_FT_SCR_BIT], div_zero, 1'b0);
  assign tx_wr = wr_done && wsel == R_HOLD;

  // Writable registers; all stay reachable while the pump is off
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      lctl_q <= `UPM_RST_BYTE;
      ien_q  <= `UPM_RST_BYTE;
      dvlo_q <= `UPM_RST_BYTE;
      dvhi_q <= `UPM_RST_BYTE;
      dvfr_q <= `UPM_RST_BYTE;
      efn_q  <= `UPM_RST_BYTE;
      feat_q <= `UPM_RST_BYTE;
      scr_q  <= `UPM_RST_BYTE;
      mctl_q <= `UPM_RST_BYTE;
      res1_q <= `UPM_RST_BYTE;
      res2_q <= `UPM_RST_BYTE;
      pau1_q <= `UPM_RST_BYTE;
      pau2_q <= `UPM_RST_BYTE;
    end else if (wr_done) begin // RULE2
      unique case (wsel)
        R_LINE_CTL:  lctl_q <= wdata_q;
        R_INT_EN:    ien_q  <= wdata_q;
        R_DIV_LO:    dvlo_q <= wdata_q; // RULE15
        R_DIV_HI:    dvhi_q <= wdata_q; // RULE15
        R_DIV_FRAC:  dvfr_q <= wdata_q & `UPM_FRAC_MASK; // RULE15
        R_ENH_FN:    efn_q  <= wdata_q;
        R_FEAT:      feat_q <= wdata_q;
        R_SCRATCH:   scr_q  <= wdata_q; // RULE18
        R_MODEM_CTL: mctl_q <= wdata_q;
        R_RES1:      res1_q <= wdata_q; // RULE17
        R_RES2:      res2_q <= wdata_q;
        R_PAUSE1:    pau1_q <= wdata_q;
        R_PAUSE2:    pau2_q <= wdata_q;
        default:     ;
      endcase
    end
  end

  // Write-only targets leave as one-cycle pulses with the byte
  assign o_tx_hold_wr  = tx_wr; // RULE14
  assign o_fifo_ctl_wr = wr_done && wsel == R_INT_SRC; // RULE19
  assign o_trig_wr     = wr_done && wsel == R_TRIG; // RULE17
  assign o_emode_wr    = wr_done && wsel == R_FIFO_LVL; // RULE18
  assign o_wr_data     = wdata_q;
  assign o_rx_hold_rd  = rd_start && rsel == R_HOLD; // RULE14
  assign o_divisor     = {dvhi_q, dvlo_q};
  assign o_div_frac    = dvfr_q;
  assign o_modem_ctl   = mctl_q;

  // Read data mux; the wake code shows only with no sources enabled
  always_comb begin
    rd_mux = `UPM_RST_BYTE;
    unique case (rsel)
      R_HOLD:       rd_mux = i_rx_hold;
      R_DIV_LO:     rd_mux = dvlo_q;
      R_DIV_HI:     rd_mux = dvhi_q;
      R_DIV_FRAC:   rd_mux = dvfr_q;
      R_REV:        rd_mux = REV_CODE; // RULE16
      R_DEVID:      rd_mux = DEV_CODE; // RULE16
      R_INT_EN:     rd_mux = ien_q;
      R_INT_SRC:    rd_mux = (wake_int_q && ien_q[3:0] == 4'h0) ?
                      {i_int_src[7:4], `UPM_SRC_WAKE} : i_int_src; // RULE11
      R_LINE_CTL:   rd_mux = lctl_q;
      R_MODEM_CTL:  rd_mux = mctl_q;
      R_LINE_STAT:  rd_mux = i_line_stat;
      R_MODEM_STAT: rd_mux = {mst_in, mst_dlt_q};
      R_SCRATCH:    rd_mux = scr_q;
      R_FIFO_LVL:   rd_mux = i_fifo_lvl;
      R_TRIG:       rd_mux = i_fifo_cnt;
      R_FEAT:       rd_mux = feat_q;
      R_ENH_FN:     rd_mux = efn_q;
      R_RES1:       rd_mux = res1_q;
      R_RES2:       rd_mux = res2_q;
      R_PAUSE1:     rd_mux = pau1_q;
      R_PAUSE2:     rd_mux = pau2_q;
    endcase
  end

  // Read data registered; pads driven one cycle after strobe seen
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_data      <= `UPM_RST_BYTE;
      o_data_oe_n <= 1'b1;
    end else begin
      o_data_oe_n <= !rd_act;
      if (rd_act) o_data <= rd_mux;
    end
  end

  // Loopback: transmit shift output feeds the receiver, modem looped
  assign loop     = mctl_q[`UPM_MC_LOOP_BIT];
  assign o_rsr_in = loop ? i_tsr_out : rx_f; // RULE12
  assign mst_in   = loop ? {mctl_q[3], mctl_q[2], mctl_q[0], mctl_q[1]}
                         : ~mdm_f; // RULE12

  // Delta bits: a change in the read cycle survives the clear
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      mst_prev_q <= 4'h0;
      mst_dlt_q  <= 4'h0;
      mdm_prev_q <= 4'hf;
      rx_prev_q  <= 1'b1;
    end else begin
      mst_prev_q <= mst_in;
      mdm_prev_q <= mdm_f;
      rx_prev_q  <= o_rsr_in;
      if (rd_start && rsel == R_MODEM_STAT) // RULE9
        mst_dlt_q <= mst_in ^ mst_prev_q;
      else
        mst_dlt_q <= mst_dlt_q | (mst_in ^ mst_prev_q);
    end
  end

  // Sleep entry and wake events; power-save blocks host writes
  assign sleep_ok = !i_int_pending && !wake_int_q && !wake_wait_q &&
                    !div_zero && ien_q[`UPM_IE_SLEEP_BIT] &&
                    mst_dlt_q == 4'h0 && o_rsr_in; // RULE21 RULE9
  assign uart_wake = (rx_prev_q && !o_rsr_in) || tx_wr ||
                     mst_dlt_q != 4'h0; // RULE8
  assign mdm_rise = (mdm_f & ~mdm_prev_q) != 4'h0;
  assign pump_wake = (!rx_prev_q && o_rsr_in) || tx_wr || mdm_rise; // RULE4

  // UART power state and the wake interrupt flag
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pwr_q       <= UPM_ACTIVE;
      wake_wait_q <= 1'b0;
      wake_int_q  <= 1'b0;
    end else begin
      unique case (pwr_q)
        UPM_ACTIVE: if (sleep_ok) pwr_q <= UPM_SLEEP; // RULE21 RULE9
        UPM_SLEEP: begin
          if (uart_wake) begin // RULE8
            pwr_q       <= UPM_ACTIVE;
            wake_wait_q <= 1'b1;
          end else if (!ien_q[`UPM_IE_SLEEP_BIT]) begin // RULE10
            pwr_q <= UPM_ACTIVE;
          end
        end
      endcase
      if (wake_wait_q && (osc_f || EXT_OSC)) begin // RULE11
        wake_wait_q <= 1'b0;
        wake_int_q  <= 1'b1;
      end else if (rd_start && rsel == R_INT_SRC) begin // RULE11
        wake_int_q <= 1'b0;
      end
    end
  end

  // Power-save follows its pin only while asleep
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) ps_q <= 1'b0;
    else ps_q <= psp_f && pwr_q == UPM_SLEEP &&
                 !uart_wake; // RULE7 RULE10
  end

  // Crystal stops in sleep; an external oscillator is never stopped
  assign o_osc_en     = EXT_OSC || pwr_q == UPM_ACTIVE; // RULE20
  assign o_asleep     = pwr_q == UPM_SLEEP;
  assign o_power_save = ps_q;
  assign o_wake_int   = wake_int_q;

  // Idle timer: any transmit or modem activity restarts it
  assign idle_done = idle_q == IDLE_CYC - 36'd1;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) idle_q <= 36'h0;
    else if (!acp_f || o_asleep || !i_tx_idle || pump_wake ||
             (mdm_f ^ mdm_prev_q) != 4'h0 || pump_q != UPM_PUMP_ON)
      idle_q <= 36'h0;
    else if (!idle_done) idle_q <= idle_q + 36'h1; // RULE1
  end

  // Charge pump: off on idle or sleep, timed recovery on wake
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pump_q <= UPM_PUMP_ON;
      wcnt_q <= 16'h0;
    end else begin
      unique case (pump_q)
        UPM_PUMP_ON:
          if (acp_f && (o_asleep || (idle_done && !pump_wake))) begin
            pump_q <= UPM_PUMP_OFF; // RULE1 RULE6
          end
        UPM_PUMP_OFF:
          if (pump_wake || !acp_f) begin // RULE4 RULE5
            pump_q <= UPM_PUMP_WAKE;
            wcnt_q <= 16'h0;
          end
        UPM_PUMP_WAKE:
          if (wcnt_q == WAKE_CYC - 16'd1) pump_q <= UPM_PUMP_ON; // RULE3
          else wcnt_q <= wcnt_q + 16'h1;
        default: pump_q <= UPM_PUMP_ON;
      endcase
    end
  end

  // Drivers float whenever the pump is fully off
  assign o_pump_en    = pump_q != UPM_PUMP_OFF;
  assign o_pump_ready = pump_q == UPM_PUMP_ON; // RULE5
  assign o_drv_oe_n   = pump_q == UPM_PUMP_OFF; // RULE2

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  a_pump_idle_off: assert property ( // RULE1
    pump_q == UPM_PUMP_ON && acp_f && idle_done && !pump_wake
    |=> pump_q == UPM_PUMP_OFF)
    else $error("pump did not stop after idle time");
  a_drv_tristate: assert property ( // RULE2
    pump_q == UPM_PUMP_OFF |-> o_drv_oe_n && !o_pump_ready)
    else $error("drivers enabled with pump off");
  a_wake_time: assert property ( // RULE3
    pump_q == UPM_PUMP_WAKE && wcnt_q == WAKE_CYC - 16'd1
    |=> o_pump_ready)
    else $error("pump not ready after recovery time");
  a_pump_restart: assert property ( // RULE4
    pump_q == UPM_PUMP_OFF && pump_wake |=> pump_q == UPM_PUMP_WAKE
    ##1 !o_drv_oe_n)
    else $error("wake event did not restart pump");
  a_sleep_pump_off: assert property ( // RULE6
    pump_q == UPM_PUMP_ON && acp_f && o_asleep |=> o_drv_oe_n)
    else $error("pump kept running while asleep");
  a_ps_isolate: assert property ( // RULE7
    o_power_save |-> $past(o_asleep) && !wr_act && !rd_act)
    else $error("power-save without sleep or bus not isolated");
  a_wake_int_set: assert property ( // RULE11
    wake_wait_q && osc_f |=> o_wake_int ##1 (o_wake_int || rd_prev_q))
    else $error("wake interrupt missing once oscillator runs");
  a_loop_route: assert property ( // RULE12
    loop |-> o_rsr_in == i_tsr_out)
    else $error("loopback path not routed");
  a_rev_read: assert property ( // RULE16
    rd_act && addr_f == `UPM_OFF_HOLD && lctl_q[`UPM_LC_DIV_BIT] &&
    lctl_q != `UPM_LINE_ENH_KEY && div_zero |=> o_data == REV_CODE)
    else $error("revision code not returned");
  a_sleep_entry: assert property ( // RULE21
    $rose(o_asleep) |-> $past(sleep_ok))
    else $error("sleep entered while conditions unmet");

  c_pump_off:   cover property (pump_q == UPM_PUMP_OFF);
  c_power_save: cover property ($rose(o_power_save));
  c_wake_int:   cover property ($rose(o_wake_int));
  c_loopback:   cover property (loop && tx_wr);

endmodule : upm_top
